// ==== mrb_link_model.sv ====
// Behavioural model of the line side: receive frame ends and transmit attempts
`timescale 1ns/1ps
`default_nettype none
module mrb_link_model (
    input wire logic ref_clk,
    output logic rxFrameDone,
    output logic rxFcsBad,
    output logic [mrb_pkg::LEN_REM_W-1:0] rxBitRemainder,
    output logic txStart,
    output logic txByteStrobe,
    output logic txCollision,
    output logic txDone
);
    import mrb_pkg::*;
    initial begin
        rxFrameDone = 1'h0;
        rxFcsBad = 1'h1;
        rxBitRemainder = 3'h5;
        txStart = 1'h0;
        txByteStrobe = 1'h0;
        txCollision = 1'h0;
        txDone = 1'h0;
    end
    // Qualifiers flip once the frame end has passed
    task automatic rx_frame(input logic bad, input logic [2:0] rem);
        @(posedge ref_clk);
        rxFrameDone <= 1'h1;
        rxFcsBad <= bad;
        rxBitRemainder <= rem;
        @(posedge ref_clk);
        rxFrameDone <= 1'h0;
        rxFcsBad <= ~bad;
        rxBitRemainder <= ~rem;
    endtask
    // Returns at the edge that samples the collision
    task automatic tx_attempt(input int nBytes, input logic hit);
        @(posedge ref_clk);
        txStart <= 1'h1;
        @(posedge ref_clk);
        txStart <= 1'h0;
        repeat (nBytes) begin
            txByteStrobe <= 1'h1;
            @(posedge ref_clk);
        end
        txByteStrobe <= 1'h0;
        txCollision <= hit;
        @(posedge ref_clk);
        txCollision <= 1'h0;
    endtask
    task automatic tx_done();
        @(posedge ref_clk);
        txDone <= 1'h1;
        @(posedge ref_clk);
        txDone <= 1'h0;
    endtask
endmodule
`default_nettype wire

// ==== mrb_pkg.sv ====
// Constants and register map of the receive buffer, frame check and retry block
// Overview of operation
// - Seven-bit buffer size at bits 10..4, 16-byte units, largest 2032 bytes, all descriptors.
// - Frame check counter counts bad-FCS frames whose bit length is a multiple of 8.
// - Reading the counter clears it, unless byte enables 0 and 1 are both low.
// - Six-bit collision window at bits 13..8 counts bytes from preamble; resets to 0x37.
// - Four-bit retry limit at bits 3..0; exhausted retries abort packet; resets to 0xF.
// - Registers and aliases accept 16- and 32-bit accesses; 8-bit accesses are ignored.
// - Unimplemented upper bits read zero and ignore writes.
package mrb_pkg;
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int IDX_MSB = 7;
    localparam int IDX_LSB = 4;
    localparam int KIND_MSB = 3;
    localparam int KIND_LSB = 2;
    // Register index in address bits 7..4
    localparam logic [3:0] IDX_BUFSZ = 4'h0;
    localparam logic [3:0] IDX_FCS = 4'h1;
    localparam logic [3:0] IDX_CLRT = 4'h2;
    localparam logic [3:0] IDX_INTSTAT = 4'h3;
    localparam logic [3:0] IDX_INTMASK = 4'h4;
    // Alias kind in address bits 3..2
    typedef enum logic [1:0] {
        MRB_PLAIN = 2'h0,
        MRB_SET = 2'h1,
        MRB_CLR = 2'h2,
        MRB_INV = 2'h3
    } mrb_alias_t;
    // Legal byte enable patterns
    localparam logic [3:0] SEL_WORD = 4'hF;
    localparam logic [3:0] SEL_LOW_HALF = 4'h3;
    localparam logic [3:0] SEL_HIGH_HALF = 4'hC;
    localparam logic [31:0] LANES_LOW = 32'h0000FFFF;
    localparam logic [31:0] LANES_HIGH = 32'hFFFF0000;
    localparam logic [31:0] LANES_ALL = 32'hFFFFFFFF;
    localparam logic [31:0] LANES_NONE = 32'h00000000;
    // Fields
    localparam int BUFSZ_LSB = 4;
    localparam int BUFSZ_W = 7;
    localparam int BUF_UNIT_SHIFT = 4;
    localparam int BUF_BYTES_W = 11;
    localparam int FCS_W = 16;
    localparam int CWIN_LSB = 8;
    localparam int CWIN_W = 6;
    localparam int RETRY_LSB = 0;
    localparam int RETRY_W = 4;
    localparam int INT_W = 4;
    localparam int LEN_REM_W = 3;
    localparam logic [6:0] BUFSZ_RESET = 7'h00;
    localparam logic [15:0] FCS_RESET = 16'h0000;
    localparam logic [15:0] FCS_MAX = 16'hFFFF;
    localparam logic [5:0] CWIN_RESET = 6'h37;
    localparam logic [3:0] RETRY_RESET = 4'hF;
    localparam logic [2:0] LEN_REM_ZERO = 3'h0;
    // Interrupt status bit positions
    localparam int INT_FCS = 0;
    localparam int INT_EXCESS = 1;
    localparam int INT_LATE = 2;
    localparam int INT_WRAP = 3;
    localparam logic [3:0] INT_RESET = 4'h0;
    localparam logic [6:0] BYTE_CNT_MAX = 7'h7F;
endpackage

// ==== mrb_retry_tracker.sv ====
// Collision window timing and retransmission count for one transmit frame
`timescale 1ns/1ps
`default_nettype none
module mrb_retry_tracker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [5:0] collisionWindow,
    input wire logic [3:0] retryLimit,
    input wire logic txStart,
    input wire logic txByteStrobe,
    input wire logic txCollision,
    input wire logic txDone,
    output logic retryRequest,
    output logic excessAbort,
    output logic lateCollision,
    output logic [3:0] attemptCount
);
    import mrb_pkg::*;

    logic [6:0] byteCount_reg;
    logic [3:0] attempt_reg;
    logic retry_reg;
    logic excess_reg;
    logic late_reg;
    logic inWindow;
    logic atLimit;

    // Bytes since the first preamble byte, window edge inclusive
    assign inWindow = byteCount_reg <= {1'b0, collisionWindow};
    assign atLimit = attempt_reg == retryLimit;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            byteCount_reg <= 7'h00;
        end else if (txStart) begin
            byteCount_reg <= 7'h00;
        end else if (txByteStrobe && byteCount_reg != BYTE_CNT_MAX) begin
            byteCount_reg <= byteCount_reg + 7'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            attempt_reg <= 4'h0;
        end else if (txDone) begin
            attempt_reg <= 4'h0;
        end else if (txCollision && inWindow) begin
            attempt_reg <= atLimit ? 4'h0 : attempt_reg + 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            retry_reg <= 1'b0;
            excess_reg <= 1'b0;
            late_reg <= 1'b0;
        end else begin
            retry_reg <= txCollision && inWindow && !atLimit;
            excess_reg <= txCollision && inWindow && atLimit;
            late_reg <= txCollision && !inWindow;
        end
    end

    assign retryRequest = retry_reg;
    assign excessAbort = excess_reg;
    assign lateCollision = late_reg;
    assign attemptCount = attempt_reg;

    sequence inWindowAtLimit;
        txCollision && !txDone && inWindow && atLimit;
    endsequence

    sequence inWindowBelowLimit;
        txCollision && !txDone && inWindow && !atLimit;
    endsequence

    chk_excess_abort: assert property (@(posedge ref_clk) disable iff (!nrst)
        inWindowAtLimit |=> excessAbort && !retryRequest && attemptCount == 4'h0)
        else $error("excess abort missing at retry limit");

    chk_retry_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        inWindowBelowLimit |=> retryRequest && attemptCount == $past(attemptCount) + 4'h1)
        else $error("retry not counted");

    chk_late_window: assert property (@(posedge ref_clk) disable iff (!nrst)
        (txStart ##1 (!txStart && !txByteStrobe) [*1] ##0 txCollision)
        |=> !lateCollision)
        else $error("collision at frame start flagged late");
endmodule
`default_nettype wire

// ==== mrb_rx_stats_retry.sv ====
// Wishbone register block for buffer size, frame check count and retry settings
`timescale 1ns/1ps
`default_nettype none
module mrb_rx_stats_retry (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [mrb_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [mrb_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [mrb_pkg::DAT_W-1:0] wb_dat_i,
    output logic [mrb_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rxFrameDone,
    input wire logic rxFcsBad,
    input wire logic [mrb_pkg::LEN_REM_W-1:0] rxBitRemainder,
    input wire logic txStart,
    input wire logic txByteStrobe,
    input wire logic txCollision,
    input wire logic txDone,
    output logic [mrb_pkg::BUFSZ_W-1:0] rxBufferSize,
    output logic [mrb_pkg::BUF_BYTES_W-1:0] rxBufferBytes,
    output logic [mrb_pkg::CWIN_W-1:0] collisionWindow,
    output logic [mrb_pkg::RETRY_W-1:0] retryLimit,
    output logic txRetry,
    output logic txExcessAbort,
    output logic txLateCollision,
    output logic irq
);
    import mrb_pkg::*;

    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [6:0] bufSize_reg;
    logic [15:0] fcsCount_reg;
    logic [15:0] fcsCount_next;
    logic [5:0] cwin_reg;
    logic [3:0] retry_reg;
    logic [3:0] intStat_reg;
    logic [3:0] intStat_next;
    logic [3:0] intMask_reg;
    logic [10:0] bufBytes_reg;
    logic [3:0] regIdx;
    mrb_alias_t aliasKind;
    logic take;
    logic accessOk;
    logic wrEn;
    logic rdEn;
    logic [31:0] laneMask;
    logic [31:0] bufWord;
    logic [31:0] fcsWord;
    logic [31:0] clrtWord;
    logic [31:0] statWord;
    logic [31:0] maskWord;
    logic [31:0] bufMerged;
    logic [31:0] fcsMerged;
    logic [31:0] clrtMerged;
    logic [31:0] maskMerged;
    logic fcsEvent;
    logic fcsReadClear;
    logic fcsWrap;
    logic excessPulse;
    logic latePulse;
    logic [3:0] events;
    logic [3:0] w1c;

    // Applies a plain, set, clear or invert write through the lane mask
    function automatic logic [31:0] mergeWrite(
        input logic [31:0] old,
        input logic [31:0] wd,
        input mrb_alias_t kind,
        input logic [31:0] lanes
    );
        logic [31:0] upd;
        case (kind)
            MRB_PLAIN: upd = wd;
            MRB_SET: upd = old | wd;
            MRB_CLR: upd = old & ~wd;
            MRB_INV: upd = old ^ wd;
            default: upd = old;
        endcase
        return (old & ~lanes) | (upd & lanes);
    endfunction

    // Request decode; a second answer is never given back to back
    assign regIdx = wb_adr_i[IDX_MSB:IDX_LSB];
    assign aliasKind = mrb_alias_t'(wb_adr_i[KIND_MSB:KIND_LSB]);
    assign take = wb_cyc_i && wb_stb_i && !ack_reg;
    assign accessOk = wb_sel_i == SEL_WORD || wb_sel_i == SEL_LOW_HALF
        || wb_sel_i == SEL_HIGH_HALF;
    assign wrEn = take && wb_we_i && accessOk;
    assign rdEn = take && !wb_we_i && accessOk;

    always_comb begin
        case (wb_sel_i)
            SEL_WORD: laneMask = LANES_ALL;
            SEL_LOW_HALF: laneMask = LANES_LOW;
            SEL_HIGH_HALF: laneMask = LANES_HIGH;
            default: laneMask = LANES_NONE;
        endcase
    end

    // Register images with unimplemented bits as zero
    assign bufWord = 32'(bufSize_reg) << BUFSZ_LSB;
    assign fcsWord = 32'(fcsCount_reg);
    assign clrtWord = (32'(cwin_reg) << CWIN_LSB) | (32'(retry_reg) << RETRY_LSB);
    assign statWord = 32'(intStat_reg);
    assign maskWord = 32'(intMask_reg);

    assign bufMerged = mergeWrite(bufWord, wb_dat_i, aliasKind, laneMask);
    assign fcsMerged = mergeWrite(fcsWord, wb_dat_i, aliasKind, laneMask);
    assign clrtMerged = mergeWrite(clrtWord, wb_dat_i, aliasKind, laneMask);
    assign maskMerged = mergeWrite(maskWord, wb_dat_i, aliasKind, laneMask);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    always_comb begin
        rdata_next = 32'h00000000;
        if (rdEn) begin
            case (regIdx)
                IDX_BUFSZ: rdata_next = bufWord;
                IDX_FCS: rdata_next = fcsWord;
                IDX_CLRT: rdata_next = clrtWord;
                IDX_INTSTAT: rdata_next = statWord;
                IDX_INTMASK: rdata_next = maskWord;
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 32'h00000000;
        end else if (take) begin
            rdata_reg <= rdata_next;
        end
    end

    // One size for all descriptors; software keeps it still while receiving
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bufSize_reg <= BUFSZ_RESET;
        end else if (wrEn && regIdx == IDX_BUFSZ) begin
            bufSize_reg <= bufMerged[BUFSZ_LSB +: BUFSZ_W];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bufBytes_reg <= 11'h000;
        end else begin
            bufBytes_reg <= BUF_BYTES_W'(bufSize_reg) << BUF_UNIT_SHIFT;
        end
    end

    // Frame check error counting and clear on read
    assign fcsEvent = rxFrameDone && rxFcsBad && rxBitRemainder == LEN_REM_ZERO;
    assign fcsReadClear = rdEn && regIdx == IDX_FCS && (wb_sel_i[0] || wb_sel_i[1]);

    always_comb begin
        fcsCount_next = fcsCount_reg;
        if (wrEn && regIdx == IDX_FCS) begin
            fcsCount_next = fcsMerged[FCS_W-1:0];
        end else if (fcsReadClear) begin
            fcsCount_next = FCS_RESET;
        end
        if (fcsEvent) begin
            fcsCount_next = fcsCount_next + 16'h0001;
        end
    end

    assign fcsWrap = fcsEvent && fcsCount_next == FCS_RESET;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fcsCount_reg <= FCS_RESET;
        end else begin
            fcsCount_reg <= fcsCount_next;
        end
    end

    // Collision window and retry limit
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cwin_reg <= CWIN_RESET;
            retry_reg <= RETRY_RESET;
        end else if (wrEn && regIdx == IDX_CLRT) begin
            cwin_reg <= clrtMerged[CWIN_LSB +: CWIN_W];
            retry_reg <= clrtMerged[RETRY_LSB +: RETRY_W];
        end
    end

    mrb_retry_tracker u_retry (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .collisionWindow(cwin_reg),
        .retryLimit(retry_reg),
        .txStart(txStart),
        .txByteStrobe(txByteStrobe),
        .txCollision(txCollision),
        .txDone(txDone),
        .retryRequest(txRetry),
        .excessAbort(excessPulse),
        .lateCollision(latePulse),
        .attemptCount()
    );

    // Sticky status, write one to clear, new events win
    always_comb begin
        events = INT_RESET;
        events[INT_FCS] = fcsEvent;
        events[INT_EXCESS] = excessPulse;
        events[INT_LATE] = latePulse;
        events[INT_WRAP] = fcsWrap;
    end

    assign w1c = (wrEn && regIdx == IDX_INTSTAT) ? (wb_dat_i[INT_W-1:0] & laneMask[INT_W-1:0])
        : INT_RESET;
    assign intStat_next = (intStat_reg & ~w1c) | events;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            intStat_reg <= INT_RESET;
        end else begin
            intStat_reg <= intStat_next;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            intMask_reg <= INT_RESET;
        end else if (wrEn && regIdx == IDX_INTMASK) begin
            intMask_reg <= maskMerged[INT_W-1:0];
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign rxBufferSize = bufSize_reg;
    assign rxBufferBytes = bufBytes_reg;
    assign collisionWindow = cwin_reg;
    assign retryLimit = retry_reg;
    assign txExcessAbort = excessPulse;
    assign txLateCollision = latePulse;
    assign irq = |(intStat_reg & intMask_reg);

    chk_buf_bytes: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 rxBufferBytes == {$past(rxBufferSize), 4'h0})
        else $error("buffer bytes not size times sixteen");

    chk_fcs_incr: assert property (@(posedge ref_clk) disable iff (!nrst)
        rxFrameDone && rxFcsBad && rxBitRemainder == LEN_REM_ZERO && !take
        |=> fcsCount_reg == $past(fcsCount_reg) + 16'h0001)
        else $error("frame check error not counted");

    chk_fcs_odd_len: assert property (@(posedge ref_clk) disable iff (!nrst)
        rxFrameDone && rxBitRemainder != LEN_REM_ZERO && !take |=> $stable(fcsCount_reg))
        else $error("odd length frame counted");

    chk_fcs_rdclr: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && !wb_we_i && regIdx == IDX_FCS && wb_sel_i == SEL_WORD && !fcsEvent
        |=> fcsCount_reg == FCS_RESET && wb_ack_o && wb_dat_o[15:0] == $past(fcsCount_reg))
        else $error("counter not cleared by read");

    chk_fcs_hi_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && !wb_we_i && regIdx == IDX_FCS && wb_sel_i == SEL_HIGH_HALF && !fcsEvent
        |=> $stable(fcsCount_reg))
        else $error("counter cleared without low byte enables");

    chk_byte_ignored: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && wb_we_i && !accessOk
        |=> $stable(bufSize_reg) && $stable(cwin_reg) && $stable(retry_reg)
            && $stable(intMask_reg))
        else $error("byte access changed a register");

    chk_upper_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && regIdx == IDX_CLRT |=> wb_dat_o[31:14] == 18'h00000 && wb_dat_o[7:4] == 4'h0)
        else $error("unimplemented bits read nonzero");

    chk_clrt_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && wb_we_i && regIdx == IDX_CLRT && aliasKind == MRB_PLAIN && wb_sel_i == SEL_WORD
        |=> cwin_reg == $past(wb_dat_i[13:8]) && retry_reg == $past(wb_dat_i[3:0]))
        else $error("collision and retry fields not written");

    chk_ack_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    chk_ack_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
        take |=> wb_ack_o)
        else $error("request not answered next cycle");

    // Counter read taken with a 16- or 32-bit byte enable pattern
    sequence fcsReadTaken;
        rdEn && regIdx == IDX_FCS;
    endsequence

    chk_fcs_rd_data: assert property (@(posedge ref_clk) disable iff (!nrst)
        fcsReadTaken |=> wb_dat_o == 32'($past(fcsCount_reg)))
        else $error("counter read data wrong");

    chk_rdclr_event: assert property (@(posedge ref_clk) disable iff (!nrst)
        fcsReadTaken ##0 (fcsReadClear && fcsEvent) |=> fcsCount_reg == 16'h0001)
        else $error("event lost on clearing read");

    chk_short_read: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && !wb_we_i && !accessOk && !fcsEvent
        |=> wb_dat_o == LANES_NONE && $stable(fcsCount_reg))
        else $error("byte read answered or cleared");

    chk_size_write: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrEn && regIdx == IDX_BUFSZ && aliasKind == MRB_PLAIN && laneMask == LANES_ALL
        |=> rxBufferSize == $past(wb_dat_i[BUFSZ_LSB +: BUFSZ_W]))
        else $error("buffer size not written");

    chk_cwin_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        !(wrEn && regIdx == IDX_CLRT) |=> $stable(cwin_reg) && $stable(retry_reg))
        else $error("collision settings changed without write");

    chk_fcs_status: assert property (@(posedge ref_clk) disable iff (!nrst)
        fcsEvent |=> intStat_reg[INT_FCS])
        else $error("frame check status not set");

    chk_excess_status: assert property (@(posedge ref_clk) disable iff (!nrst)
        excessPulse |=> intStat_reg[INT_EXCESS])
        else $error("excess abort status not set");

    chk_late_status: assert property (@(posedge ref_clk) disable iff (!nrst)
        latePulse |=> intStat_reg[INT_LATE])
        else $error("late collision status not set");

    chk_wrap_status: assert property (@(posedge ref_clk) disable iff (!nrst)
        fcsWrap |=> intStat_reg[INT_WRAP] && fcsCount_reg == FCS_RESET)
        else $error("counter wrap not flagged");

    chk_stat_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrEn && regIdx == IDX_INTSTAT && events == INT_RESET
        |=> (intStat_reg & $past(w1c)) == INT_RESET)
        else $error("status bit not cleared by write");

    chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (!nrst)
        intMask_reg == INT_RESET |-> !irq)
        else $error("interrupt raised while all masked");
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the buffer size, frame check count and retry block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import mrb_pkg::*;
    logic ref_clk, nrst, cyc, stb, we, ack, irq;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] wdat, datO, rdat;
    logic rxFrameDone, rxFcsBad, txStart, txByteStrobe, txCollision, txDone;
    logic [LEN_REM_W-1:0] rxBitRemainder;
    logic [BUFSZ_W-1:0] rxBufferSize;
    logic [BUF_BYTES_W-1:0] rxBufferBytes;
    logic [CWIN_W-1:0] collisionWindow;
    logic [RETRY_W-1:0] retryLimit;
    logic txRetry, txExcessAbort, txLateCollision;
    int nErrors = 0;
    int checkCount = 0;
    mrb_rx_stats_retry i_dut (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO),
        .wb_ack_o(ack), .rxFrameDone(rxFrameDone), .rxFcsBad(rxFcsBad),
        .rxBitRemainder(rxBitRemainder), .txStart(txStart), .txByteStrobe(txByteStrobe),
        .txCollision(txCollision), .txDone(txDone), .rxBufferSize(rxBufferSize),
        .rxBufferBytes(rxBufferBytes), .collisionWindow(collisionWindow),
        .retryLimit(retryLimit), .txRetry(txRetry), .txExcessAbort(txExcessAbort),
        .txLateCollision(txLateCollision), .irq(irq));
    mrb_link_model i_link (.ref_clk(ref_clk), .rxFrameDone(rxFrameDone), .rxFcsBad(rxFcsBad),
        .rxBitRemainder(rxBitRemainder), .txStart(txStart), .txByteStrobe(txByteStrobe),
        .txCollision(txCollision), .txDone(txDone));
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'h1);
        rdat = datO;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        check("ack delay", 32'h2, 32'(n));
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] e,
        input string what);
        wb(1'h0, a, s, 32'h0);
        check(what, e, rdat);
    endtask
    task automatic attempt(input int n, input logic [2:0] e);
        i_link.tx_attempt(n, 1'h1);
        #1;
        check("late/abort/retry", {29'h0, e}, {29'h0, txLateCollision, txExcessAbort, txRetry});
    endtask
    task automatic test_end(input string name);
        $display("test %s finished, mismatches so far %0d", name, nErrors);
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk);
        check("watchdog", 32'h1, 32'h0);
        print_verdict();
    end
    initial begin
        nrst = 1'h0;
        cyc = 1'h0;
        stb = 1'h0;
        we = 1'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'h1;
        rd(8'h20, SEL_WORD, 32'h0000370F, "collision_retry_config");
        rd(8'h00, SEL_WORD, 32'h0, "rx_buffer_size_ctrl");
        rd(8'h10, SEL_WORD, 32'h0, "fcs_error_counter");
        check("window", 32'h37, {26'h0, collisionWindow});
        check("limit", 32'hF, {28'h0, retryLimit});
        test_end("reset");
        // Receive stays idle during size changes
        wb(1'h1, 8'h00, SEL_WORD, 32'hFFFFFFFF);
        rd(8'h00, SEL_WORD, 32'h000007F0, "rx_buffer_size_ctrl");
        check("rxBufferBytes", 32'h7F0, {21'h0, rxBufferBytes});
        wb(1'h1, 8'h00, SEL_LOW_HALF, 32'h00000120);
        rd(8'h00, SEL_WORD, 32'h120, "size half");
        wb(1'h1, 8'h04, SEL_WORD, 32'h10);
        rd(8'h00, SEL_WORD, 32'h130, "size set");
        wb(1'h1, 8'h08, SEL_WORD, 32'h20);
        rd(8'h00, SEL_WORD, 32'h110, "size clear");
        wb(1'h1, 8'h0C, SEL_WORD, 32'h7F0);
        rd(8'h00, SEL_WORD, 32'h6E0, "size invert");
        for (int i = 0; i < 4; i++) wb(1'h1, 8'h00, 4'h1 << i, 32'h0);
        rd(8'h00, SEL_WORD, 32'h6E0, "size after byte writes");
        rd(8'h00, 4'h1, 32'h0, "byte read");
        check("rxBufferSize", 32'h6E, {25'h0, rxBufferSize});
        check("rxBufferBytes", 32'h6E0, {21'h0, rxBufferBytes});
        test_end("buffer size");
        i_link.rx_frame(1'h1, 3'h0);
        i_link.rx_frame(1'h1, 3'h3);
        i_link.rx_frame(1'h0, 3'h0);
        i_link.rx_frame(1'h1, 3'h0);
        i_link.rx_frame(1'h1, 3'h7);
        wb(1'h0, 8'h10, SEL_HIGH_HALF, 32'h0);
        rd(8'h10, 4'h1, 32'h0, "counter byte read");
        rd(8'h10, SEL_WORD, 32'h2, "fcs_error_counter");
        rd(8'h10, SEL_WORD, 32'h0, "counter after read");
        // Direct counter write, debug use only
        wb(1'h1, 8'h10, SEL_WORD, 32'h0000FFFF);
        i_link.rx_frame(1'h1, 3'h0);
        rd(8'h10, SEL_LOW_HALF, 32'h0, "counter wrap");
        wb(1'h1, 8'h14, SEL_WORD, 32'h5);
        rd(8'h10, SEL_WORD, 32'h5, "counter set alias");
        rd(8'h30, SEL_WORD, 32'h9, "interrupt status");
        test_end("frame check count");
        check("irq masked", 32'h0, {31'h0, irq});
        wb(1'h1, 8'h40, SEL_WORD, 32'h1);
        check("irq unmasked", 32'h1, {31'h0, irq});
        wb(1'h1, 8'h30, SEL_WORD, 32'h1);
        check("irq cleared", 32'h0, {31'h0, irq});
        rd(8'h30, SEL_WORD, 32'h8, "status after clear");
        wb(1'h1, 8'h30, SEL_WORD, 32'h8);
        test_end("interrupt");
        wb(1'h1, 8'h20, SEL_WORD, 32'hFFFF0402);
        rd(8'h20, SEL_WORD, 32'h402, "collision_retry_config");
        check("window", 32'h4, {26'h0, collisionWindow});
        check("limit", 32'h2, {28'h0, retryLimit});
        attempt(4, 3'h1);
        attempt(4, 3'h1);
        attempt(4, 3'h2);
        i_link.tx_done();
        attempt(5, 3'h4);
        i_link.tx_done();
        attempt(1, 3'h1);
        i_link.tx_done();
        wb(1'h1, 8'h20, SEL_LOW_HALF, 32'h00000400);
        attempt(2, 3'h2);
        i_link.tx_done();
        attempt(0, 3'h2);
        i_link.tx_done();
        rd(8'h30, SEL_WORD, 32'h6, "status after transmit");
        wb(1'h1, 8'h40, SEL_WORD, 32'hF);
        check("irq transmit", 32'h1, {31'h0, irq});
        wb(1'h1, 8'h3C, SEL_WORD, 32'h6);
        check("irq after clear", 32'h0, {31'h0, irq});
        wb(1'h1, 8'h50, SEL_WORD, 32'hFFFFFFFF);
        rd(8'h50, SEL_WORD, 32'h0, "unmapped");
        test_end("retry");
        print_verdict();
    end
endmodule
`default_nettype wire
